// [dctm_defs.vh]
`ifndef DCTM_DEFS_VH
`define DCTM_DEFS_VH
// ==========================================
// register word index (avalon word address)
`define DCTM_IDX_MADDR 2'h0
`define DCTM_IDX_PADDR 2'h1
`define DCTM_IDX_COUNT 2'h2
`define DCTM_IDX_CTRL 2'h3
`define DCTM_IDX_MASTER 4'h8
`define DCTM_HALF_BIT 2
`define DCTM_GLOBAL_BIT 3
// ==========================================
// control register fields
`define DCTM_CT_TE 0
`define DCTM_CT_IE 1
`define DCTM_CT_SZ 2
`define DCTM_CT_DEC 3
`define DCTM_CT_STEP 4
`define DCTM_CT_MODE 6:5
`define DCTM_CT_BLK 7
`define DCTM_CT_TMS 8
`define DCTM_CT_SRC 11:9
`define DCTM_CT_W 12
`define DCTM_CT_RST 12'h000
// ==========================================
// master register fields
`define DCTM_MS_ME 0
`define DCTM_MS_BUSY 1
// ==========================================
// modes
`define DCTM_MODE_IO 2'h0
`define DCTM_MODE_IDLE 2'h1
`define DCTM_MODE_REPT 2'h2
`define DCTM_MODE_FULL 2'h3
// ==========================================
// activation sources
`define DCTM_SRC_TXE 3'h4
`define DCTM_SRC_RXF 3'h5
`define DCTM_SRC_AUTO_BURST 3'h0
`define DCTM_SRC_AUTO_STEAL 3'h2
// ==========================================
// constants
`define DCTM_PERIPH_HIGH 16'hffff
`define DCTM_CNT_LAST16 16'h0001
`define DCTM_CNT_LAST8 8'h01
`endif

// [dctm_sync.v]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// three-stage pin synchroniser, output moves when stages two and three agree
module dctm_sync #(
	parameter RST_VAL = 1'b1
) (
	input wire clk,
	input wire rst,
	input wire pin,
	output reg level
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge clk) begin
		if (rst) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			level <= RST_VAL;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level <= s3_reg;
		end
	end
endmodule
`default_nettype wire

// [dctm_channel.v]
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dctm_defs.vh"
module dctm_channel (
	input wire clk,
	input wire rst,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire [3:0] timer_evt,
	input wire serial_tx_empty,
	input wire serial_rx_full,
	input wire ext_req_n,
	input wire nmi,
	output wire bus_req,
	input wire bus_grant,
	output reg [23:0] m_addr,
	output wire m_read,
	output wire m_write,
	output wire m_word,
	output wire [15:0] m_wdata,
	input wire [15:0] m_rdata,
	input wire m_ack,
	output reg [1:0] end_irq
);
	localparam ST_IDLE = 2'h0;
	localparam ST_REQ = 2'h1;
	localparam ST_RD = 2'h2;
	localparam ST_WR = 2'h3;

	reg [23:0] memory_address_reg [0:1];
	reg [7:0] peripheral_address_low_reg [0:1];
	reg [15:0] transfer_count_reg [0:1];
	reg [11:0] ctrl_reg [0:1];
	reg master_transfer_enable_reg;
	reg [1:0] state_reg;
	reg cur_reg;
	reg full_reg;
	reg rx_reg;
	reg [1:0] pend_reg;
	reg [15:0] data_reg;
	reg rd_ack_reg;
	reg pin_prev_reg;
	wire pin_level;

	// ==========================================
	// step and restore helpers
	function [23:0] fstep;
		input [23:0] a;
		input en;
		input dec;
		input sz;
		reg [23:0] s;
		begin
			s = {22'h0, sz, ~sz};
			if (!en)
				fstep = a;
			else if (dec)
				fstep = a - s;
			else
				fstep = a + s;
		end
	endfunction

	function [23:0] frest;
		input [23:0] a;
		input dec;
		input sz;
		input [7:0] n;
		reg [23:0] span;
		begin
			span = sz ? {15'h0, n, 1'b0} : {16'h0000, n};
			frest = dec ? a + span : a - span;
		end
	endfunction

	// ==========================================
	// external request pin
	dctm_sync #(
		.RST_VAL(1'b1)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.pin(ext_req_n),
		.level(pin_level)
	);

	always @(posedge clk) begin
		if (rst)
			pin_prev_reg <= 1'b1;
		else
			pin_prev_reg <= pin_level;
	end

	// ==========================================
	// activation decode
	wire [11:0] c0 = ctrl_reg[0];
	wire [11:0] c1 = ctrl_reg[1];
	wire full = c0[`DCTM_CT_MODE] == `DCTM_MODE_FULL;
	wire pin_fall = pin_prev_reg & ~pin_level;
	// only the B half and full mode take the external pin
	wire [7:0] vec_a = {2'b00, serial_rx_full, serial_tx_empty, timer_evt};
	wire [7:0] vec_b = {~pin_level, pin_fall, serial_rx_full, serial_tx_empty, timer_evt};
	wire ev0 = full ? vec_b[c0[`DCTM_CT_SRC]] : vec_a[c0[`DCTM_CT_SRC]];
	wire ev1 = vec_b[c1[`DCTM_CT_SRC]];
	wire auto0 = full & ~c0[`DCTM_CT_BLK] &
		(c0[`DCTM_CT_SRC] == `DCTM_SRC_AUTO_BURST | c0[`DCTM_CT_SRC] == `DCTM_SRC_AUTO_STEAL);
	wire burst0 = auto0 & (c0[`DCTM_CT_SRC] == `DCTM_SRC_AUTO_BURST);
	wire me = master_transfer_enable_reg;
	wire go0 = me & c0[`DCTM_CT_TE] & (auto0 | pend_reg[0]);
	wire go1 = me & c1[`DCTM_CT_TE] & ~full & pend_reg[1] &
		(c1[`DCTM_CT_MODE] != `DCTM_MODE_FULL);
	wire take0 = (state_reg == ST_IDLE) & go0;
	wire take1 = (state_reg == ST_IDLE) & ~go0 & go1;

	// ==========================================
	// unit update values
	wire upd = (state_reg == ST_WR) & m_ack;
	wire [11:0] cc = ctrl_reg[cur_reg];
	wire [23:0] ma = memory_address_reg[cur_reg];
	wire [15:0] cn = transfer_count_reg[cur_reg];
	wire [1:0] md = cc[`DCTM_CT_MODE];
	wire [23:0] sh_adv = fstep(ma, md != `DCTM_MODE_IDLE, cc[`DCTM_CT_DEC], cc[`DCTM_CT_SZ]);
	wire [23:0] fa_adv = fstep(memory_address_reg[0], c0[`DCTM_CT_STEP], c0[`DCTM_CT_DEC], c0[`DCTM_CT_SZ]);
	wire [23:0] fb_adv = fstep(memory_address_reg[1], c1[`DCTM_CT_STEP], c1[`DCTM_CT_DEC], c0[`DCTM_CT_SZ]);
	wire rept_wrap = cn[15:8] == `DCTM_CNT_LAST8;
	wire blk_end = transfer_count_reg[0][15:8] == `DCTM_CNT_LAST8;
	wire blk_mode = full_reg & c0[`DCTM_CT_BLK];
	reg fin;
	always @* begin
		if (full_reg)
			fin = blk_mode ? blk_end & (transfer_count_reg[1] == `DCTM_CNT_LAST16)
				: transfer_count_reg[0] == `DCTM_CNT_LAST16;
		else
			fin = (md != `DCTM_MODE_REPT) & (cn == `DCTM_CNT_LAST16);
	end
	// keep the bus inside a block or a burst, drop it otherwise
	wire cont = full_reg & ~fin & me & ~nmi & cc[`DCTM_CT_TE] &
		((burst0 & ~blk_mode) | (blk_mode & ~blk_end));

	// ==========================================
	// bus side
	wire [23:0] periph = {`DCTM_PERIPH_HIGH, peripheral_address_low_reg[cur_reg]};
	assign bus_req = state_reg != ST_IDLE;
	assign m_read = state_reg == ST_RD;
	assign m_write = state_reg == ST_WR;
	assign m_word = full_reg ? c0[`DCTM_CT_SZ] : cc[`DCTM_CT_SZ];
	assign m_wdata = data_reg;

	always @* begin
		if (full_reg)
			m_addr = m_read ? memory_address_reg[0] : memory_address_reg[1];
		else if (rx_reg)
			m_addr = m_read ? periph : ma;
		else
			m_addr = m_read ? ma : periph;
	end

	// ==========================================
	// transfer engine state
	always @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cur_reg <= 1'b0;
			full_reg <= 1'b0;
			rx_reg <= 1'b0;
			data_reg <= 16'h0000;
			pend_reg <= 2'b00;
		end else begin
			// a new request wins over the clear of the one being taken
			// transfer enable off drops requests, so no stale unit runs after set-up;
			// master enable off keeps them for the resume
			pend_reg[0] <= c0[`DCTM_CT_TE] & (ev0 | (pend_reg[0] & ~take0));
			pend_reg[1] <= c1[`DCTM_CT_TE] & (ev1 | (pend_reg[1] & ~take1));
			case (state_reg)
			ST_IDLE: begin
				if (take0 | take1) begin
					cur_reg <= take1;
					full_reg <= take0 & full;
					rx_reg <= (take1 ? c1[`DCTM_CT_SRC] : c0[`DCTM_CT_SRC]) == `DCTM_SRC_RXF;
					state_reg <= ST_REQ;
				end
			end
			ST_REQ: begin
				if (bus_grant)
					state_reg <= ST_RD;
			end
			ST_RD: begin
				if (m_ack) begin
					data_reg <= m_rdata;
					state_reg <= ST_WR;
				end
			end
			ST_WR: begin
				if (m_ack) begin
					if (!cont)
						state_reg <= ST_IDLE;
					else if (bus_grant)
						state_reg <= ST_RD;
					else
						state_reg <= ST_REQ;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// registers: software access, then engine, then nmi
	assign avs_waitrequest = avs_read & ~rd_ack_reg;
	wire wr_half = avs_address[`DCTM_HALF_BIT];
	wire wr_loc = avs_write & ~avs_address[`DCTM_GLOBAL_BIT];

	always @(posedge clk) begin
		if (rst) begin
			memory_address_reg[0] <= 24'h000000;
			memory_address_reg[1] <= 24'h000000;
			peripheral_address_low_reg[0] <= 8'h00;
			peripheral_address_low_reg[1] <= 8'h00;
			transfer_count_reg[0] <= 16'h0000;
			transfer_count_reg[1] <= 16'h0000;
			ctrl_reg[0] <= `DCTM_CT_RST;
			ctrl_reg[1] <= `DCTM_CT_RST;
			master_transfer_enable_reg <= 1'b0;
			end_irq <= 2'b00;
		end else begin
			end_irq <= 2'b00;
			if (wr_loc) begin
				case (avs_address[1:0])
				`DCTM_IDX_MADDR: memory_address_reg[wr_half] <= avs_writedata[23:0];
				`DCTM_IDX_PADDR: peripheral_address_low_reg[wr_half] <= avs_writedata[7:0];
				`DCTM_IDX_COUNT: transfer_count_reg[wr_half] <= avs_writedata[15:0];
				default: ctrl_reg[wr_half] <= avs_writedata[11:0];
				endcase
			end
			if (avs_write && avs_address == `DCTM_IDX_MASTER)
				master_transfer_enable_reg <= avs_writedata[`DCTM_MS_ME];
			if (upd && !full_reg) begin
				case (md)
				`DCTM_MODE_REPT: begin
					if (rept_wrap) begin
						transfer_count_reg[cur_reg][15:8] <= cn[7:0];
						memory_address_reg[cur_reg] <= frest(sh_adv, cc[`DCTM_CT_DEC],
							cc[`DCTM_CT_SZ], cn[7:0]);
					end else begin
						transfer_count_reg[cur_reg][15:8] <= cn[15:8] - 8'h01;
						memory_address_reg[cur_reg] <= sh_adv;
					end
				end
				default: begin
					memory_address_reg[cur_reg] <= sh_adv;
					transfer_count_reg[cur_reg] <= cn - 16'h0001;
					if (fin) begin
						ctrl_reg[cur_reg][`DCTM_CT_TE] <= 1'b0;
						end_irq[cur_reg] <= cc[`DCTM_CT_IE];
					end
				end
				endcase
			end
			if (upd && full_reg) begin
				memory_address_reg[0] <= fa_adv;
				memory_address_reg[1] <= fb_adv;
				if (!blk_mode) begin
					transfer_count_reg[0] <= transfer_count_reg[0] - 16'h0001;
				end else if (blk_end) begin
					transfer_count_reg[0][15:8] <= transfer_count_reg[0][7:0];
					transfer_count_reg[1] <= transfer_count_reg[1] - 16'h0001;
					if (c0[`DCTM_CT_TMS])
						memory_address_reg[0] <= frest(fa_adv, c0[`DCTM_CT_DEC],
							c0[`DCTM_CT_SZ], transfer_count_reg[0][7:0]);
					else
						memory_address_reg[1] <= frest(fb_adv, c1[`DCTM_CT_DEC],
							c0[`DCTM_CT_SZ], transfer_count_reg[0][7:0]);
				end else begin
					transfer_count_reg[0][15:8] <= transfer_count_reg[0][15:8] - 8'h01;
				end
				if (fin) begin
					ctrl_reg[0][`DCTM_CT_TE] <= 1'b0;
					end_irq[0] <= c0[`DCTM_CT_IE];
				end
			end
			if (nmi)
				master_transfer_enable_reg <= 1'b0;
		end
	end

	// ==========================================
	// avalon read, one wait cycle
	always @(posedge clk) begin
		if (rst) begin
			rd_ack_reg <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			rd_ack_reg <= avs_read & ~rd_ack_reg;
			if (avs_read && !rd_ack_reg) begin
				if (avs_address == `DCTM_IDX_MASTER)
					avs_readdata <= {30'h0, bus_req, me};
				else if (avs_address[`DCTM_GLOBAL_BIT])
					avs_readdata <= 32'h00000000;
				else begin
					case (avs_address[1:0])
					`DCTM_IDX_MADDR: avs_readdata <= {8'h00, memory_address_reg[wr_half]};
					`DCTM_IDX_PADDR: avs_readdata <= {24'h000000, peripheral_address_low_reg[wr_half]};
					`DCTM_IDX_COUNT: avs_readdata <= {16'h0000, transfer_count_reg[wr_half]};
					default: avs_readdata <= {20'h00000, ctrl_reg[wr_half]};
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

// [dctm_mem.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// memory side: grants one cycle after the request, acks every other try, scrambles idle data
module dctm_mem (
	input wire logic clk,
	input wire logic bus_req,
	output logic bus_grant,
	input wire logic [23:0] m_addr,
	input wire logic m_read,
	input wire logic m_write,
	output logic [15:0] m_rdata,
	output logic m_ack
);
	logic [1:0] w = 2'h0;
	initial begin
		bus_grant = 1'b0;
		m_ack = 1'b0;
		m_rdata = 16'h0000;
	end
	always @(posedge clk) begin
		bus_grant <= bus_req;
		w <= w + 2'h1;
		m_ack <= (m_read || m_write) && !m_ack && w[0];
		m_rdata <= (m_read && !m_ack) ? {m_addr[7:0] ^ 8'ha5, m_addr[7:0]} : ~m_rdata;
	end
endmodule
`default_nettype wire

// [dctm_channel_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checks
module dctm_channel_sva (
	input wire clk,
	input wire rst,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire nmi,
	input wire bus_req,
	input wire bus_grant,
	input wire [23:0] m_addr,
	input wire m_read,
	input wire m_write,
	input wire [15:0] m_wdata,
	input wire m_ack,
	input wire [1:0] end_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("read answered without wait");
	read_answer_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest || !avs_read)
		else $error("read wait too long");
	write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
		else $error("write was stalled");
	rw_excl_a: assert property (!(m_read && m_write))
		else $error("read and write together");
	read_hold_a: assert property (m_read && !m_ack |=> m_read && $stable(m_addr))
		else $error("read dropped before ack");
	read_then_write_a: assert property (m_read && m_ack |=> m_write && !m_read)
		else $error("unit not completed by a write");
	write_hold_a: assert property (m_write && !m_ack |=> m_write && $stable(m_addr) && $stable(m_wdata))
		else $error("write changed before ack");
	grant_first_a: assert property ($rose(m_read) |-> $past(bus_grant))
		else $error("bus used without grant");
	bus_owned_a: assert property (m_read || m_write |-> bus_req)
		else $error("access without bus request");
	irq_pulse_a: assert property (end_irq[0] |=> !end_irq[0])
		else $error("end pulse longer than one cycle");
	nmi_stop_a: assert property (nmi ##1 !bus_req |-> !bus_req [*4])
		else $error("transfer started after nmi");
endmodule
bind dctm_channel dctm_channel_sva dctm_channel_sva_i (.clk(clk), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .nmi(nmi), .bus_req(bus_req),
	.bus_grant(bus_grant), .m_addr(m_addr), .m_read(m_read), .m_write(m_write), .m_wdata(m_wdata),
	.m_ack(m_ack), .end_irq(end_irq));
`default_nettype wire

// [dctm_channel_bench.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========
// bench
module dctm_channel_bench;
	logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, serial_tx_empty = 0, serial_rx_full = 0, nmi = 0;
	logic [3:0] avs_address = 4'h0, timer_evt = 4'h0, hb = 4'h0;
	logic [31:0] avs_writedata = 32'h0, q;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, bus_req, bus_grant, m_read, m_write, m_word, m_ack;
	wire [23:0] m_addr;
	wire [15:0] m_wdata, m_rdata;
	wire [1:0] end_irq;
	logic [23:0] e_src, e_dst, st, ra, e_start;
	logic [15:0] r = 16'h000a;
	logic sz, rx;
	logic [1:0] md = 2'h0;
	logic ext_req_n = 1'b1;
	int errors = 0, n_compared = 0, units = 0, irqs = 0, t, k;
	always #5 clk = ~clk;
	dctm_channel dctm_channel_i (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .timer_evt(timer_evt), .serial_tx_empty(serial_tx_empty),
		.serial_rx_full(serial_rx_full), .ext_req_n(ext_req_n), .nmi(nmi), .bus_req(bus_req), .bus_grant(bus_grant),
		.m_addr(m_addr), .m_read(m_read), .m_write(m_write), .m_word(m_word), .m_wdata(m_wdata),
		.m_rdata(m_rdata), .m_ack(m_ack), .end_irq(end_irq));
	dctm_mem dctm_mem_i (.clk(clk), .bus_req(bus_req), .bus_grant(bus_grant), .m_addr(m_addr),
		.m_read(m_read), .m_write(m_write), .m_rdata(m_rdata), .m_ack(m_ack));
	function logic [15:0] lf(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task print_verdict;
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task bus(input logic [3:0] a, input logic rd, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			errors++;
			print_verdict;
		end
	endtask
	task ev(input logic [2:0] s);
		@(posedge clk);
		timer_evt <= s < 3'h4 ? 4'h1 << s : 4'h0;
		serial_tx_empty <= s == 3'h4;
		serial_rx_full <= s == 3'h5;
		@(posedge clk);
		timer_evt <= 4'h0;
		serial_tx_empty <= 1'b0;
		serial_rx_full <= 1'b0;
	endtask
	task waitu(input int n);
		int i;
		for (i = 0; i < 300 && units < n; i++)
			@(posedge clk);
		chk(units, n);
		if (i >= 300)
			print_verdict;
	endtask
	task cfg(input logic [2:0] s, input logic d, input logic ie, input logic [15:0] n);
		logic [23:0] m;
		logic [7:0] p;
		m = {r, r[7:0]};
		p = r[15:8];
		sz = r[4];
		rx = s == 3'h5;
		st = d ? (sz ? 24'hfffffe : 24'hffffff) : (sz ? 24'h000002 : 24'h000001);
		e_start = m;
		e_src = rx ? {16'hffff, p} : m;
		e_dst = rx ? m : {16'hffff, p};
		units = 0;
		irqs = 0;
		bus(hb, 1'b0, {8'h00, m});
		bus(hb | 4'h1, 1'b0, {24'h0, p});
		bus(hb | 4'h2, 1'b0, {16'h0, n});
		bus(hb | 4'h3, 1'b0, {20'h0, s, 2'h0, md, 1'b0, d, sz, ie, 1'b1});
	endtask
	task fin(input logic [2:0] s, input logic ie, input int n);
		repeat (3) @(posedge clk);
		chk(irqs, ie);
		bus(hb | 4'h2, 1'b1, 32'h0);
		chk(q, 32'h0);
		bus(hb | 4'h3, 1'b1, 32'h0);
		chk(q[0], 1'b0);
		bus(hb, 1'b1, 32'h0);
		chk(q, rx ? e_dst : e_src);
		ev(s);
		repeat (20) @(posedge clk);
		chk(units, n);
	endtask
	// ==========
	// unit monitor
	always @(posedge clk) begin
		if (m_read && m_ack)
			ra <= m_addr;
		if (m_write && m_ack) begin
			chk(ra, e_src);
			chk(m_addr, e_dst);
			chk(m_word, sz);
			chk(m_wdata, {ra[7:0] ^ 8'ha5, ra[7:0]});
			// idle mode holds both addresses
			if (md != 2'h1) begin
				if (rx)
					e_dst <= e_dst + st;
				else
					e_src <= e_src + st;
			end
			units <= units + 1;
		end
		if (end_irq[hb[2]])
			irqs <= irqs + 1;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		bus(4'h9, 1'b0, 32'hffffffff);
		bus(4'h9, 1'b1, 32'h0);
		chk(q, 32'h0);
		bus(4'h8, 1'b1, 32'h0);
		chk(q, 32'h0);
		bus(4'h8, 1'b0, 32'h1);
		for (t = 0; t < 6; t++) begin
			r = lf(r);
			cfg(t[2:0], r[5], r[6], {14'h0, r[1:0]} + 16'h1);
			for (k = 1; k <= r[1:0] + 1; k++) begin
				ev(t[2:0]);
				waitu(k);
			end
			fin(t[2:0], r[6], r[1:0] + 1);
		end
		// ==========
		// idle mode: addresses fixed, count and interrupt as io mode
		md = 2'h1;
		r = lf(r);
		cfg(3'h4, r[5], r[6], 16'h2);
		for (k = 1; k <= 2; k++) begin
			ev(3'h4);
			waitu(k);
		end
		fin(3'h4, r[6], 2);
		// ==========
		// repeat mode: address and count restored, no interrupt
		md = 2'h2;
		r = lf(r);
		cfg(3'h1, r[5], 1'b1, 16'h0202);
		for (k = 1; k <= 2; k++) begin
			ev(3'h1);
			waitu(k);
		end
		repeat (3) @(posedge clk);
		chk(irqs, 0);
		bus(4'h2, 1'b1, 32'h0);
		chk(q, 32'h0202);
		bus(4'h0, 1'b1, 32'h0);
		chk(q, e_start);
		bus(4'h3, 1'b1, 32'h0);
		chk(q[0], 1'b1);
		bus(4'h3, 1'b0, 32'h0);
		md = 2'h0;
		// ==========
		// master enable and nmi
		cfg(3'h0, 1'b0, 1'b1, 16'h2);
		bus(4'h8, 1'b0, 32'h0);
		ev(3'h0);
		repeat (20) @(posedge clk);
		chk(units, 0);
		bus(4'h8, 1'b0, 32'h1);
		waitu(1);
		@(posedge clk);
		nmi <= 1'b1;
		@(posedge clk);
		nmi <= 1'b0;
		repeat (6) @(posedge clk);
		bus(4'h8, 1'b1, 32'h0);
		chk(q[0], 1'b0);
		ev(3'h0);
		repeat (20) @(posedge clk);
		chk(units, 1);
		bus(4'h8, 1'b0, 32'h1);
		waitu(2);
		fin(3'h0, 1'b1, 2);
		// ==========
		// half b on a falling edge of the request pin
		hb = 4'h4;
		r = lf(r);
		cfg(3'h6, r[5], 1'b1, 16'h1);
		@(posedge clk);
		ext_req_n <= 1'b0;
		repeat (5) @(posedge clk);
		ext_req_n <= 1'b1;
		waitu(1);
		fin(3'h6, 1'b1, 1);
		print_verdict;
	end
endmodule
`default_nettype wire
